//--- common/mbx_pkg.sv
// package for the mono expand blit engine: register map, field layout, states and carriers.
// assumes a single 125 mhz clock and an ahb-lite register bus with 32-bit data.
//
// Notes on behaviour
// - control register bit 31 shows busy; host reprograms nothing until idle.
// - mask select bit 13 with bits 16-14 zero uses mono source as write mask.
// - control bit 12 set marks source monochrome, so it is colour-expanded.
// - control bit 11 clear puts the destination in frame buffer memory.
// - control bit 10 set takes source from host data port writes.
// - field 9-8 at 00 means host data starts at top-left pixel.
// - control bits 7-0 pick the raster operation; cch copies source unchanged.
// - raster operations without pattern input never fetch pattern data.
// - pattern field 22-17 is disregarded when pattern is not needed.
// - mono control bit 27 clear takes foreground from shared expansion colour.
// - mono control bits 26-24 give alignment; 101 means one aligned quadword.
// - three six-bit clipping fields at zero perform no clipping.
// - offset bits 28-16 give destination pitch in bytes between lines.
// - with mono source the byte source pitch field 12-0 is ignored.
// - at 8 bpp only colour bits 7-0 are used, bits 23-8 ignored.
// - at 8 bpp every written pixel is a palette index.
// - with mono write masking background pixels are never written.
// - with host mono source the source address field is ignored.
// - destination address bits 22-0 give byte offset of first pixel.
// - size bits 28-16 give height in lines, 12-0 width in bytes.
// - writing non-zero height starts the operation; program everything first. the engine also needs a non-zero width in the same write.
package mbx_pkg;
    // register word indices, byte address is index times four
    localparam logic [5:0] IDX_PITCH = 6'h00;
    localparam logic [5:0] IDX_BG_EXP = 6'h01;
    localparam logic [5:0] IDX_FG_EXP = 6'h02;
    localparam logic [5:0] IDX_MONO = 6'h03;
    localparam logic [5:0] IDX_CTRL = 6'h04;
    localparam logic [5:0] IDX_PAT = 6'h05;
    localparam logic [5:0] IDX_SRC = 6'h06;
    localparam logic [5:0] IDX_DST = 6'h07;
    localparam logic [5:0] IDX_SIZE = 6'h08;
    localparam logic [5:0] IDX_SRC_BG = 6'h09;
    localparam logic [5:0] IDX_SRC_FG = 6'h0a;
    localparam logic [5:0] IDX_DATA = 6'h10;
    // field positions
    localparam int CTRL_BUSY = 31;
    localparam int CTRL_PAT_NEED = 30;
    localparam int CTRL_MASK_SEL = 13;
    localparam int CTRL_MONO = 12;
    localparam int CTRL_DST_SYS = 11;
    localparam int CTRL_SRC_HOST = 10;
    localparam int MONO_FG_SEL = 27;
    localparam int FLD13_HI = 16;
    // reset value and copy raster operation code
    localparam logic [31:0] RST_REG = 32'h0000_0000;
    localparam logic [7:0] ROP_COPY = 8'hcc;
    // pixel step and host word size in source bits
    localparam logic [5:0] STEP_MONO = 6'h01;
    localparam logic [5:0] STEP_COLOR = 6'h08;
    localparam logic [5:0] WORD_BITS = 6'h20;

    typedef enum logic [2:0] {
        MBX_IDLE = 3'b001,
        MBX_FETCH = 3'b010,
        MBX_PIX = 3'b100
    } mbx_state_t;

    // one frame buffer byte write
    typedef struct packed {
        logic [22:0] addr;
        logic [7:0] data;
    } mbx_fb_wr_t;
endpackage : mbx_pkg

//--- rtl/mbx_engine.sv
// mono expand blit engine: ahb-lite register slave, host data port and pixel writer.
// assumes a frame buffer write port that takes one byte per cycle while fb_ready is high.
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
module mbx_engine (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic fb_valid,
    output mbx_pkg::mbx_fb_wr_t fb_wr,
    input wire logic fb_ready
);
    ////////////////////////////////////////////////////////////////////////////
    // registers and state
    logic [31:0] src_dst_pitch;
    logic [31:0] bg_expand_color;
    logic [31:0] fg_expand_color;
    logic [31:0] mono_source_control;
    logic [31:0] blit_control;
    logic [31:0] pattern_address;
    logic [31:0] source_address;
    logic [31:0] dest_address;
    logic [31:0] dest_size;
    logic [31:0] source_bg_color;
    logic [31:0] source_fg_color;
    mbx_pkg::mbx_state_t state;
    logic ap_valid;
    logic ap_wr;
    logic [5:0] ap_idx;
    logic [31:0] hold;
    logic hold_full;
    logic [31:0] sh;
    logic [5:0] bits_left;
    logic [22:0] addr;
    logic [22:0] line_start;
    logic [12:0] x_left;
    logic [12:0] y_left;
    logic new_ap;
    logic reg_wr;
    logic dp_wait;
    logic dp_take;
    logic busy;
    logic start;
    logic go;
    logic emit;
    logic [5:0] step;
    logic last_pix;
    logic line_end;
    logic [7:0] fg_sel;
    logic [7:0] bg_sel;
    logic [7:0] pix;
    logic wen;
    logic pat_need;
    logic mono;
    logic mask_en;
    logic [31:0] rd_mux;

    ////////////////////////////////////////////////////////////////////////////
    // bus decode and status terms
    assign new_ap = hsel && htrans[1] && hready;
    assign reg_wr = ap_valid && ap_wr && hreadyout && (ap_idx != mbx_pkg::IDX_DATA);
    assign dp_wait = ap_valid && ap_wr && !hreadyout && (ap_idx == mbx_pkg::IDX_DATA);
    assign busy = (state != mbx_pkg::MBX_IDLE) || fb_valid;
    assign dp_take = dp_wait && !hold_full && busy;
    assign start = reg_wr && !busy && (ap_idx == mbx_pkg::IDX_SIZE)
        && (hwdata[28:16] != 13'h0000);
    // a start runs only for a host source into the frame buffer with a non-zero written width
    assign go = start && blit_control[mbx_pkg::CTRL_SRC_HOST] && !blit_control[mbx_pkg::CTRL_DST_SYS]
        && (hwdata[12:0] != 13'h0000);
    assign pat_need = blit_control[7:4] != blit_control[3:0];
    assign mono = blit_control[mbx_pkg::CTRL_MONO];
    assign mask_en = blit_control[mbx_pkg::CTRL_MASK_SEL] && (blit_control[16:14] == 3'h0);
    assign step = mono ? mbx_pkg::STEP_MONO : mbx_pkg::STEP_COLOR;

    // foreground and background source pick, low byte only at 8 bpp
    assign fg_sel = mono_source_control[mbx_pkg::MONO_FG_SEL] ? source_fg_color[7:0]
        : fg_expand_color[7:0];
    assign bg_sel = mono_source_control[mbx_pkg::MONO_FG_SEL] ? source_bg_color[7:0]
        : bg_expand_color[7:0];

    // read mux, busy and pattern need shown live in the control word
    always_comb begin
        case (ap_idx)
            mbx_pkg::IDX_PITCH: rd_mux = src_dst_pitch;
            mbx_pkg::IDX_BG_EXP: rd_mux = bg_expand_color;
            mbx_pkg::IDX_FG_EXP: rd_mux = fg_expand_color;
            mbx_pkg::IDX_MONO: rd_mux = mono_source_control;
            mbx_pkg::IDX_CTRL: rd_mux = {busy, pat_need, blit_control[29:0]};
            mbx_pkg::IDX_PAT: rd_mux = pattern_address;
            mbx_pkg::IDX_SRC: rd_mux = source_address;
            mbx_pkg::IDX_DST: rd_mux = dest_address;
            mbx_pkg::IDX_SIZE: rd_mux = dest_size;
            mbx_pkg::IDX_SRC_BG: rd_mux = source_bg_color;
            mbx_pkg::IDX_SRC_FG: rd_mux = source_fg_color;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // ahb-lite handshake: reads and data port writes wait, register writes do not
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_valid <= 1'b0;
            ap_wr <= 1'b0;
            ap_idx <= 6'h00;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0000_0000;
        end else if (ce) begin
            hresp <= 1'b0;
            if (new_ap) begin
                ap_valid <= 1'b1;
                ap_wr <= hwrite;
                ap_idx <= haddr[7:2];
                if (!hwrite || (haddr[7:2] == mbx_pkg::IDX_DATA)) begin
                    hreadyout <= 1'b0;
                end
            end else if (ap_valid && !hreadyout) begin
                if (!ap_wr) begin
                    hrdata <= rd_mux;
                    hreadyout <= 1'b1;
                    ap_valid <= 1'b0;
                end else if (!(hold_full && busy)) begin
                    hreadyout <= 1'b1;
                    ap_valid <= 1'b0;
                end
            end else begin
                ap_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register writes, locked while the engine is busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_dst_pitch <= mbx_pkg::RST_REG;
            bg_expand_color <= mbx_pkg::RST_REG;
            fg_expand_color <= mbx_pkg::RST_REG;
            mono_source_control <= mbx_pkg::RST_REG;
            blit_control <= mbx_pkg::RST_REG;
            pattern_address <= mbx_pkg::RST_REG;
            source_address <= mbx_pkg::RST_REG;
            dest_address <= mbx_pkg::RST_REG;
            dest_size <= mbx_pkg::RST_REG;
            source_bg_color <= mbx_pkg::RST_REG;
            source_fg_color <= mbx_pkg::RST_REG;
        end else if (ce && reg_wr && !busy) begin
            case (ap_idx)
                mbx_pkg::IDX_PITCH: src_dst_pitch <= hwdata;
                mbx_pkg::IDX_BG_EXP: bg_expand_color <= hwdata;
                mbx_pkg::IDX_FG_EXP: fg_expand_color <= hwdata;
                mbx_pkg::IDX_MONO: mono_source_control <= hwdata;
                mbx_pkg::IDX_CTRL: blit_control <= {2'b00, hwdata[29:0]};
                mbx_pkg::IDX_PAT: pattern_address <= hwdata;
                mbx_pkg::IDX_SRC: source_address <= hwdata;
                mbx_pkg::IDX_DST: dest_address <= hwdata;
                mbx_pkg::IDX_SIZE: dest_size <= hwdata;
                mbx_pkg::IDX_SRC_BG: source_bg_color <= hwdata;
                mbx_pkg::IDX_SRC_FG: source_fg_color <= hwdata;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // host data holding word: filled by the data port, emptied by the engine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hold <= 32'h0000_0000;
            hold_full <= 1'b0;
        end else if (ce) begin
            if (dp_take) begin
                hold <= hwdata;
                hold_full <= 1'b1;
            end else if (state == mbx_pkg::MBX_FETCH) begin
                hold_full <= 1'b0;
            end else if (state == mbx_pkg::MBX_IDLE) begin
                hold_full <= 1'b0; // leftover data dropped after the rectangle
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pixel walk: left to right, top to bottom, bits msb first
    assign emit = (state == mbx_pkg::MBX_PIX) && (!fb_valid || fb_ready);
    assign line_end = x_left == 13'h0001;
    assign last_pix = line_end && (y_left == 13'h0001);

    mbx_pixel u_pixel (
        .mono(mono),
        .mask_en(mask_en),
        .src_bit(sh[31]),
        .src_byte(sh[31:24]),
        .fg(fg_sel),
        .bg(bg_sel),
        .rop(blit_control[7:0]),
        .pix(pix),
        .wen(wen)
    );

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= mbx_pkg::MBX_IDLE;
            sh <= 32'h0000_0000;
            bits_left <= 6'h00;
            addr <= 23'h000000;
            line_start <= 23'h000000;
            x_left <= 13'h0000;
            y_left <= 13'h0000;
        end else if (ce) begin
            case (state)
                mbx_pkg::MBX_IDLE: begin
                    // width comes from the size write itself, the register only updates at this edge
                    if (go) begin
                        addr <= dest_address[22:0];
                        line_start <= dest_address[22:0];
                        x_left <= hwdata[12:0];
                        y_left <= hwdata[28:16];
                        state <= mbx_pkg::MBX_FETCH;
                    end
                end
                mbx_pkg::MBX_FETCH: begin
                    if (hold_full) begin
                        sh <= hold;
                        bits_left <= mbx_pkg::WORD_BITS;
                        state <= mbx_pkg::MBX_PIX;
                    end
                end
                mbx_pkg::MBX_PIX: begin
                    if (emit) begin
                        sh <= mono ? {sh[30:0], 1'b0} : {sh[23:0], 8'h00};
                        bits_left <= bits_left - step;
                        if (last_pix) begin
                            state <= mbx_pkg::MBX_IDLE;
                        end else begin
                            if (line_end) begin
                                y_left <= y_left - 13'h0001;
                                x_left <= dest_size[12:0];
                                line_start <= line_start + {10'h000, src_dst_pitch[28:16]};
                                addr <= line_start + {10'h000, src_dst_pitch[28:16]};
                            end else begin
                                x_left <= x_left - 13'h0001;
                                addr <= addr + 23'h000001;
                            end
                            if (bits_left == step) begin
                                state <= mbx_pkg::MBX_FETCH;
                            end
                        end
                    end
                end
                default: state <= mbx_pkg::MBX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // frame buffer write port, held until fb_ready
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fb_valid <= 1'b0;
            fb_wr <= '0;
        end else if (ce) begin
            if (emit) begin
                fb_valid <= wen;
                fb_wr.addr <= addr;
                fb_wr.data <= pix;
            end else if (fb_ready) begin
                fb_valid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    AST_START_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && go) |=> (state == mbx_pkg::MBX_FETCH) && busy)
        else $error("start did not make the engine busy");

    AST_LOCK_BUSY: assert property (@(posedge hclk) disable iff (!hresetn)
        (reg_wr && busy) |=> $stable(dest_address) && $stable(blit_control) && $stable(dest_size))
        else $error("register changed while busy");

    AST_FIRST_ADDR: assert property (@(posedge hclk) disable iff (!hresetn)
        ($past(state) == mbx_pkg::MBX_IDLE && state == mbx_pkg::MBX_FETCH) |-> addr == dest_address[22:0])
        else $error("first pixel address is not the destination");

    AST_PITCH: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && emit && line_end && !last_pix)
        |=> line_start == $past(line_start) + {10'h000, src_dst_pitch[28:16]})
        else $error("next line does not start one pitch later");

    AST_MASK_FG: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && emit && mono && mask_en && blit_control[7:0] == mbx_pkg::ROP_COPY)
        |=> (fb_valid == $past(sh[31])) && (!fb_valid || fb_wr.data == $past(fg_sel)))
        else $error("masked write wrote a background pixel");

    AST_COPY: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && emit && mono && !mask_en && blit_control[7:0] == mbx_pkg::ROP_COPY)
        |=> fb_valid && fb_wr.data == ($past(sh[31]) ? $past(fg_sel) : $past(bg_sel)))
        else $error("copy operation altered the expanded source");

    AST_DP_STALL: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && dp_wait && hold_full && busy && state != mbx_pkg::MBX_FETCH) |=> !hreadyout)
        else $error("data port write not stalled with full hold word");

    AST_FB_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        (fb_valid && !fb_ready) |=> fb_valid && $stable(fb_wr))
        else $error("frame buffer write dropped before accept");

    AST_IDLE_QUIET: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(fb_valid) |-> $past(state) == mbx_pkg::MBX_PIX)
        else $error("pixel written without host source data");

    AST_PAT_NEED: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && ap_valid && !ap_wr && !hreadyout && ap_idx == mbx_pkg::IDX_CTRL)
        |=> hrdata[mbx_pkg::CTRL_PAT_NEED] == $past(pat_need) && hrdata[mbx_pkg::CTRL_BUSY] == $past(busy))
        else $error("control read shows wrong status");

    AST_START_SIZE: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && go) |=> x_left == $past(hwdata[12:0]) && y_left == $past(hwdata[28:16]))
        else $error("rectangle size not taken from the size write");

    AST_IDLE_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && dp_wait && !busy) |=> hreadyout && !hold_full)
        else $error("data port write while idle was not dropped");

    AST_COLOR_COPY: assert property (@(posedge hclk) disable iff (!hresetn)
        (ce && emit && !mono && blit_control[7:0] == mbx_pkg::ROP_COPY)
        |=> fb_valid && fb_wr.data == $past(sh[31:24]))
        else $error("colour source byte not copied");
endmodule : mbx_engine

//--- rtl/mbx_pixel.sv
// per-pixel colour expansion, raster operation and write mask for 8 bpp.
// assumes pattern and destination inputs of the raster operation read as zero.
`timescale 1ns/100ps
module mbx_pixel (
    input wire logic mono,
    input wire logic mask_en,
    input wire logic src_bit,
    input wire logic [7:0] src_byte,
    input wire logic [7:0] fg,
    input wire logic [7:0] bg,
    input wire logic [7:0] rop,
    output logic [7:0] pix,
    output logic wen
);
    logic [7:0] src_exp;

    // expand mono bit to a palette index, else take the colour byte
    assign src_exp = mono ? (src_bit ? fg : bg) : src_byte;

    // bitwise raster operation, indexed by the source bit with pattern and destination bits taken as zero
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_rop
            assign pix[i] = src_exp[i] ? rop[2] : rop[0];
        end
    endgenerate

    // masked background pixels are skipped
    assign wen = !(mono && mask_en && !src_bit);
endmodule : mbx_pixel

//--- verification/mbx_engine_tb.sv
// self-checking bench for the mono expand blit engine.
// assumes the engine at word addresses of four times the register index.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module mbx_engine_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout;
    logic [31:0] hrdata;
    logic hresp;
    logic fb_valid;
    logic fb_ready;
    mbx_pkg::mbx_fb_wr_t fb_wr;
    int n_mismatch = 0;
    int n_tests = 0;
    ////////////////////////////////////////////////////////////////////////////////
    // clock and instances
    always #4 hclk = ~hclk;
    mbx_engine mbx_engine_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fb_valid(fb_valid), .fb_wr(fb_wr),
        .fb_ready(fb_ready));
    mbx_fb_model mbx_fb_model_i (.hclk(hclk), .hresetn(hresetn), .fb_valid(fb_valid), .fb_wr(fb_wr),
        .fb_ready(fb_ready));
    ////////////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic report_and_stop();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    // bounded wait for an edge with hready high
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 1000) begin
                n_mismatch++;
                report_and_stop();
            end
            @(posedge hclk);
        end
    endtask : wait_ready
    // one single ahb-lite word transfer, index times four gives the byte address
    task automatic xfer(input logic wr, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, idx, 2'h0};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : xfer
    task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, idx, wd, d);
    endtask : wr
    task automatic rd(input logic [5:0] idx, output logic [31:0] d);
        xfer(1'b0, idx, 32'h0, d);
    endtask : rd
    // poll until busy clears, bounded
    task automatic wait_idle();
        logic [31:0] d;
        for (int i = 0; i < 300; i++) begin
            rd(mbx_pkg::IDX_CTRL, d);
            if (d[31] === 1'b0) begin
                return;
            end
        end
        n_mismatch++;
        report_and_stop();
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic test_reset_and_map();
        logic [31:0] d;
        rd(mbx_pkg::IDX_CTRL, d);
        `CHK(d, 32'h0000_0000)
        wr(6'h0b, 32'hdead_beef);
        rd(6'h0b, d);
        `CHK(d, 32'h0000_0000)
        wr(mbx_pkg::IDX_DST, 32'h0012_3456);
        rd(mbx_pkg::IDX_DST, d);
        `CHK(d, 32'h0012_3456)
        $display("test_reset_and_map done");
    endtask : test_reset_and_map
    task automatic test_zero_height();
        logic [31:0] d;
        wr(mbx_pkg::IDX_CTRL, 32'h0000_34cc);
        wr(mbx_pkg::IDX_SIZE, 32'h0000_0008);
        rd(mbx_pkg::IDX_CTRL, d);
        `CHK(d[31], 1'b0)
        `CHK(mbx_fb_model_i.q_addr.size(), 0)
        $display("test_zero_height done");
    endtask : test_zero_height
    // 8x8 masked character from two host words
    task automatic test_char_blit();
        logic [31:0] d;
        logic [63:0] src;
        logic [22:0] ea[$];
        src = 64'h8000_0001_ff00_0080;
        for (int i = 0; i < 64; i++) begin
            if (src[63 - i]) begin
                ea.push_back(23'h020080 + 23'((i / 8) * 'h400 + (i % 8)));
            end
        end
        wr(mbx_pkg::IDX_PITCH, 32'h0400_0123);
        wr(mbx_pkg::IDX_BG_EXP, 32'h0000_0033);
        wr(mbx_pkg::IDX_FG_EXP, 32'h00ab_cd5a);
        wr(mbx_pkg::IDX_MONO, 32'h0500_0000);
        wr(mbx_pkg::IDX_CTRL, 32'h007e_34cc);
        wr(mbx_pkg::IDX_SRC, 32'h007f_ffff);
        wr(mbx_pkg::IDX_DST, 32'h0002_0080);
        wr(mbx_pkg::IDX_SIZE, 32'h0008_0008);
        rd(mbx_pkg::IDX_CTRL, d);
        `CHK(d[31], 1'b1)
        `CHK(d[30], 1'b0)
        wr(mbx_pkg::IDX_DST, 32'h0000_0000);
        wr(mbx_pkg::IDX_DATA, src[63:32]);
        wr(mbx_pkg::IDX_DATA, src[31:0]);
        `CHK(hresp, 1'b0)
        wait_idle();
        rd(mbx_pkg::IDX_DST, d);
        `CHK(d, 32'h0002_0080)
        `CHK(mbx_fb_model_i.q_addr.size(), ea.size())
        for (int i = 0; i < ea.size() && i < mbx_fb_model_i.q_addr.size(); i++) begin
            `CHK(mbx_fb_model_i.q_addr[i], ea[i])
            `CHK(mbx_fb_model_i.q_data[i], 8'h5a)
        end
        wr(mbx_pkg::IDX_DATA, 32'hffff_ffff);
        `CHK(mbx_fb_model_i.q_addr.size(), ea.size())
        $display("test_char_blit done");
    endtask : test_char_blit
    // unmasked expansion with the source colour pair; the third word stalls on a full hold word
    task automatic test_expand_stall();
        logic [95:0] w;
        int n0;
        w = 96'ha5a5_a5a5_0f0f_0f0f_8000_0001;
        n0 = mbx_fb_model_i.q_addr.size();
        wr(mbx_pkg::IDX_PITCH, 32'h0010_0000);
        wr(mbx_pkg::IDX_MONO, 32'h0800_0000);
        wr(mbx_pkg::IDX_SRC_FG, 32'h0000_0077);
        wr(mbx_pkg::IDX_SRC_BG, 32'h0000_0011);
        wr(mbx_pkg::IDX_CTRL, 32'h0000_14cc);
        wr(mbx_pkg::IDX_DST, 32'h0000_1000);
        wr(mbx_pkg::IDX_SIZE, 32'h0018_0004);
        wr(mbx_pkg::IDX_DATA, w[95:64]);
        wr(mbx_pkg::IDX_DATA, w[63:32]);
        wr(mbx_pkg::IDX_DATA, w[31:0]);
        wait_idle();
        `CHK(mbx_fb_model_i.q_addr.size(), n0 + 96)
        for (int i = 0; i < 96 && n0 + i < mbx_fb_model_i.q_addr.size(); i++) begin
            `CHK(mbx_fb_model_i.q_addr[n0 + i], 23'h001000 + 23'((i / 4) * 'h10 + (i % 4)))
            `CHK(mbx_fb_model_i.q_data[n0 + i], w[95 - i] ? 8'h77 : 8'h11)
        end
        $display("test_expand_stall done");
    endtask : test_expand_stall
    // colour source: one byte per pixel, leftmost byte first
    task automatic test_color_copy();
        int n0;
        n0 = mbx_fb_model_i.q_addr.size();
        wr(mbx_pkg::IDX_CTRL, 32'h0000_04cc);
        wr(mbx_pkg::IDX_DST, 32'h0000_0200);
        wr(mbx_pkg::IDX_SIZE, 32'h0001_0004);
        wr(mbx_pkg::IDX_DATA, 32'h1122_3344);
        wait_idle();
        `CHK(mbx_fb_model_i.q_addr.size(), n0 + 4)
        for (int i = 0; i < 4 && n0 + i < mbx_fb_model_i.q_addr.size(); i++) begin
            `CHK(mbx_fb_model_i.q_addr[n0 + i], 23'h000200 + 23'(i))
            `CHK(mbx_fb_model_i.q_data[n0 + i], 8'h11 * 8'(i + 1))
        end
        $display("test_color_copy done");
    endtask : test_color_copy
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        test_reset_and_map();
        test_zero_height();
        test_char_blit();
        test_expand_stall();
        test_color_copy();
        report_and_stop();
    end
endmodule : mbx_engine_tb

//--- verification/mbx_fb_model.sv
// frame buffer write port model: records every accepted byte write.
// assumes one write per edge where fb_valid and fb_ready are both high.
`timescale 1ns/100ps
module mbx_fb_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic fb_valid,
    input wire mbx_pkg::mbx_fb_wr_t fb_wr,
    output logic fb_ready
);
    logic [1:0] stall_cnt;
    logic [22:0] q_addr[$];
    logic [7:0] q_data[$];
    ////////////////////////////////////////////////////////////////////////////////
    // stall one edge in four so held requests are exercised
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stall_cnt <= 2'h0;
        end else begin
            stall_cnt <= stall_cnt + 2'h1;
        end
    end
    assign fb_ready = (stall_cnt != 2'h3);
    // log accepted writes in order
    always @(posedge hclk) begin
        if (hresetn && fb_valid === 1'b1 && fb_ready) begin
            q_addr.push_back(fb_wr.addr);
            q_data.push_back(fb_wr.data);
        end
    end
endmodule : mbx_fb_model
